/* File: hdl/output_line_pulse_generator.sv */
// output line pulse generator: source select, edge qualify, lead delay, pulse width
//
// Decided for this implementation: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ns
module output_line_pulse_generator
   import pulse_out_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // avalon-mm slave
   input  wire logic [3:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   // event sources
   input  wire logic        second_input_pin,
   input  wire logic        net_command_1,
   input  wire logic        net_command_2,
   input  wire logic        exposure_active,
   // output line
   output logic             line_out
);
   import pulse_out_pkg::*;

   // settings registers
   logic [2:0]             source_q;
   logic [1:0]             edge_q;
   logic [count_width-1:0] lead_q;
   logic [count_width-1:0] width_q;
   logic                   host_fire_q;
   state_type              state_q;
   state_type              state_d;
   logic [count_width-1:0] cnt_q;
   logic [count_width-1:0] cnt_d;
   logic                   src_q;
   logic [31:0]            rdata_d;
   logic                   line_d;

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
      merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction

   // input 2 is a pin, so it is synchronised before any logic looks at it
   logic input2_sync;
   sync_two_flop u_sync (
      .clk      (clk),
      .rst_n    (rst_n),
      .async_in (second_input_pin),
      .sync_out (input2_sync)
   );

   // bus decode; one wait cycle so read data always come from a register
   wire access   = read || write;
   wire do_write = write && !waitrequest;
   wire wr_ctrl  = do_write && (address == ctrl_offset);
   wire wr_lead  = do_write && (address == lead_offset);
   wire wr_width = do_write && (address == width_offset);
   wire wr_fire  = do_write && (address == fire_offset) && byteenable[0];

   // unmapped addresses read zero and ignore writes
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (address == ctrl_offset) begin
         rdata_d = {24'h00_0000, state_q, edge_q, 1'b0, source_q};
      end else if (address == lead_offset) begin
         rdata_d = {16'h0000, lead_q};
      end else if (address == width_offset) begin
         rdata_d = {16'h0000, width_q};
      end else if (address == fire_offset) begin
         rdata_d = {31'h0000_0000, line_out};
      end
   end

   // waitrequest is a flop: high while idle, low for the one cycle after a request is seen
   // same latency as a decoded version, and the bus output carries no decode glitches
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         waitrequest <= 1'b1;
         readdata    <= 32'h0000_0000;
      end else begin
         waitrequest <= !(access && waitrequest);
         readdata    <= rdata_d;
      end
   end

   // settings storage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         source_q <= source_reset;
         edge_q   <= edge_reset;
         lead_q   <= lead_reset;
         width_q  <= width_reset;
      end else begin
         if (wr_ctrl && byteenable[0]) begin
            source_q <= writedata[source_lsb +: source_width];
            edge_q   <= writedata[edge_lsb +: edge_width];
         end
         if (wr_lead) begin
            lead_q <= merge16(lead_q, writedata, byteenable);
         end
         if (wr_width) begin
            width_q <= merge16(width_q, writedata, byteenable);
         end
      end
   end

   // host fire bit: only bit line_index of the mask concerns this line
   wire host_fire = wr_fire && writedata[line_index];

   // the host command is a one-cycle high level so an upward edge follows
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         host_fire_q <= 1'b0;
      end else begin
         host_fire_q <= host_fire;
      end
   end

   // source selection
   wire src_level = (source_q == pulse_on_second_input)       ? input2_sync :
                    (source_q == pulse_on_first_net_command)  ? net_command_1 :
                    (source_q == pulse_on_second_net_command) ? net_command_2 :
                    (source_q == pulse_on_host_command)       ? host_fire_q :
                    1'b0;

   // edge qualification; host pulses count as an edge in any mode
   wire rise    = src_level && !src_q;
   wire fall    = !src_level && src_q;
   wire host_src = (source_q == pulse_on_host_command);
   wire trig    = host_src ? rise :
                  (edge_q == upward_transition)   ? rise :
                  (edge_q == downward_transition) ? fall :
                  (edge_q == either_transition)   ? rise || fall :
                  1'b0;
   wire level_mode = (source_q == exposure_level_output);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         src_q <= 1'b0;
      end else begin
         src_q <= src_level;
      end
   end

   // microsecond tick restarted on each accepted trigger
   wire start = trig && (state_q == st_idle) && !level_mode;
   logic tick;
   us_tick_gen u_tick (
      .clk     (clk),
      .rst_n   (rst_n),
      .restart (start),
      .tick    (tick)
   );

   // lead delay then pulse width, triggers ignored when not idle
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      case (state_q)
         st_idle: begin
            if (start) begin
               cnt_d = lead_q;
               state_d = (lead_q == '0) ? st_pulse : st_lead;
               if (lead_q == '0) begin
                  cnt_d = width_q;
               end
            end
         end
         st_lead: begin
            if (tick) begin
               if (cnt_q <= 16'h0001) begin
                  state_d = st_pulse;
                  cnt_d   = width_q;
               end else begin
                  cnt_d = cnt_q - 1'b1;
               end
            end
         end
         st_pulse: begin
            if (tick) begin
               if (cnt_q <= 16'h0001) begin
                  state_d = st_idle;
                  cnt_d   = '0;
               end else begin
                  cnt_d = cnt_q - 1'b1;
               end
            end
         end
         default: begin
            state_d = st_idle;
            cnt_d   = '0;
         end
      endcase
      if (level_mode) begin
         state_d = st_idle;
         cnt_d   = '0;
      end
   end

   // exposure mode bypasses the timer; one flop delay keeps the output registered
   assign line_d = level_mode ? exposure_active : (state_d == st_pulse);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q  <= st_idle;
         cnt_q    <= '0;
         line_out <= 1'b0;
      end else begin
         state_q  <= state_d;
         cnt_q    <= cnt_d;
         line_out <= line_d;
      end
   end

   // assertions
   // each timer step is checked on its own so a failure points at the step that broke
   sequence s_fire;
      start && lead_q == '0;
   endsequence

   sequence s_lead_done;
      state_q == st_lead && tick && cnt_q <= 16'h0001 && !level_mode;
   endsequence

   sequence s_lead_step;
      state_q == st_lead && tick && cnt_q > 16'h0001 && !level_mode;
   endsequence

   sequence s_pulse_done;
      state_q == st_pulse && tick && cnt_q <= 16'h0001 && !level_mode;
   endsequence

   // a rise of net command 2 while idle, with that command selected
   sequence s_net2_rise;
      state_q == st_idle && source_q == pulse_on_second_net_command && edge_q == upward_transition
         && net_command_2 && !src_q;
   endsequence

   // timer: lead count, pulse start, hold and end, no stray output
   a_busy_ignore: assert property (@(posedge clk) disable iff (!rst_n)
      (state_q == st_lead && !tick && !level_mode) |=> (state_q == st_lead && $stable(cnt_q)))
      else $error("trigger disturbed the lead count");
   a_zero_lead_pulse: assert property (@(posedge clk) disable iff (!rst_n)
      s_fire |=> line_out)
      else $error("zero lead did not pulse at once");
   a_lead_quiet: assert property (@(posedge clk) disable iff (!rst_n)
      (start && lead_q != '0) |=> (!line_out)[*2])
      else $error("output rose during lead time");
   a_lead_step: assert property (@(posedge clk) disable iff (!rst_n)
      s_lead_step |=> (state_q == st_lead && cnt_q == $past(cnt_q) - 16'h0001))
      else $error("lead count did not step down");
   a_lead_to_pulse: assert property (@(posedge clk) disable iff (!rst_n)
      s_lead_done |=> (state_q == st_pulse && line_out))
      else $error("pulse did not start after the lead time");
   a_pulse_hold: assert property (@(posedge clk) disable iff (!rst_n)
      (state_q == st_pulse && !tick && !level_mode) |=> line_out)
      else $error("pulse dropped early");
   a_pulse_ends: assert property (@(posedge clk) disable iff (!rst_n)
      s_pulse_done |=> !line_out)
      else $error("pulse did not end");
   a_idle_quiet: assert property (@(posedge clk) disable iff (!rst_n)
      (state_q == st_idle && !start && !level_mode) |=> !line_out)
      else $error("output high with no trigger");

   // edge filter, judged by what the timer does next rather than by the trigger wire
   a_up_only: assert property (@(posedge clk) disable iff (!rst_n)
      (state_q == st_idle && !level_mode && !host_src && edge_q == upward_transition && fall)
         |=> (state_q == st_idle))
      else $error("falling edge taken in upward mode");
   a_down_only: assert property (@(posedge clk) disable iff (!rst_n)
      (state_q == st_idle && !level_mode && !host_src && edge_q == downward_transition && rise)
         |=> (state_q == st_idle))
      else $error("rising edge taken in downward mode");
   a_either_edge: assert property (@(posedge clk) disable iff (!rst_n)
      (state_q == st_idle && !level_mode && !host_src && edge_q == either_transition && (rise || fall))
         |=> (state_q != st_idle))
      else $error("edge missed in either mode");

   // exposure level mode bypasses the timer entirely
   a_exposure_follow: assert property (@(posedge clk) disable iff (!rst_n)
      (level_mode && $stable(source_q)) |=> (line_out == $past(exposure_active)))
      else $error("exposure level not followed");
   a_level_idle: assert property (@(posedge clk) disable iff (!rst_n)
      level_mode |=> (state_q == st_idle))
      else $error("timer ran in exposure level mode");

   // source routing: net command and host fire mask
   a_net_select: assert property (@(posedge clk) disable iff (!rst_n)
      s_net2_rise |=> (state_q != st_idle))
      else $error("net command 2 did not fire");
   a_host_fire: assert property (@(posedge clk) disable iff (!rst_n)
      (host_fire && host_src && state_q == st_idle) |=> ##1 (state_q != st_idle))
      else $error("host fire lost");
   a_fire_mask: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_fire && !writedata[line_index]) |=> !host_fire_q)
      else $error("fire bit of another output fired this line");

   // tick spacing: a restart can only stretch the gap, never shorten it
   a_tick_gap: assert property (@(posedge clk) disable iff (!rst_n)
      tick |=> (!tick)[*8])
      else $error("microsecond ticks too close");
endmodule

/* File: hdl/pulse_out_pkg.sv */
// package: register map, field layout, encodings and timing for the output line pulse block
package pulse_out_pkg;
   // avalon word addresses are byte addresses, one aligned word each
   localparam logic [3:0]  ctrl_offset      = 4'h0;
   localparam logic [3:0]  lead_offset      = 4'h4;
   localparam logic [3:0]  width_offset     = 4'h8;
   localparam logic [3:0]  fire_offset      = 4'hc;
   localparam int          addr_width       = 4;
   // ctrl register fields
   localparam int          source_lsb       = 0;
   localparam int          source_width     = 3;
   localparam int          edge_lsb         = 4;
   localparam int          edge_width       = 2;
   localparam int          count_width      = 16;
   localparam int          outputs_num      = 4;
   // this block drives output number line_index; bit 1 of the fire mask is output 1
   localparam int          line_index       = 1;
   // reset values
   localparam logic [2:0]  source_reset     = 3'h0;
   localparam logic [1:0]  edge_reset       = 2'h0;
   localparam logic [15:0] lead_reset       = 16'h0000;
   localparam logic [15:0] width_reset      = 16'h0001;
   // microsecond tick from the 20 MHz clock
   localparam int          clk_mhz          = 20;
   localparam int          tick_time_us     = 1;
   localparam int          tick_cycles      = tick_time_us * clk_mhz;
   localparam int          tick_width       = 5;

   typedef enum logic [2:0] {
      pulse_on_second_input       = 3'b000,
      pulse_on_first_net_command  = 3'b001,
      pulse_on_second_net_command = 3'b010,
      pulse_on_host_command       = 3'b011,
      exposure_level_output       = 3'b100
   } source_type;

   typedef enum logic [1:0] {
      upward_transition   = 2'b00,
      downward_transition = 2'b01,
      either_transition   = 2'b10
   } edge_type;

   typedef enum logic [1:0] {
      st_idle  = 2'b00,
      st_lead  = 2'b01,
      st_pulse = 2'b10
   } state_type;
endpackage

/* File: hdl/sync_two_flop.sv */
// two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ns
module sync_two_flop (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // level in and out
   input  wire logic async_in,
   output logic      sync_out
);
   logic meta_q;

   // first stage read by the second only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q   <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

/* File: hdl/us_tick_gen.sv */
// microsecond tick generator running off the block clock
`timescale 1ns/1ns
module us_tick_gen
   import pulse_out_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // restart and tick
   input  wire logic restart,
   output logic      tick
);
   logic [tick_width-1:0] cnt_q;
   logic [tick_width-1:0] cnt_d;
   wire                   wrap = (cnt_q == tick_width'(tick_cycles - 1));
   // the tick flop is set one count early so it is seen exactly tick_cycles after a restart
   wire                   last = (cnt_q == tick_width'(tick_cycles - 2));

   // restart aligns the first microsecond with the trigger
   assign cnt_d = (restart || wrap) ? '0 : cnt_q + 1'b1;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         tick  <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick  <= last && !restart;
      end
   end
endmodule

/* File: tb/strobe_light.sv */
// strobe light model: counts pulses on the output line and times each one
`timescale 1ns/1ns
module strobe_light (
   // clock and reset
   input  wire logic   clk,
   input  wire logic   rst_n,
   // output line from the device
   input  wire logic   line_in,
   // pulse count and last high time in cycles
   output logic [7:0]  count_q,
   output logic [15:0] width_q
);
   logic [15:0] run_q;
   logic        prev_q;
   // a light only sees on time, so each high phase is timed whole
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= 8'h00;
         width_q <= 16'h0000;
         run_q   <= 16'h0000;
         prev_q  <= 1'b0;
      end else begin
         if (line_in && !prev_q) count_q <= count_q + 8'h01;
         if (!line_in && prev_q) width_q <= run_q;
         run_q  <= line_in ? run_q + 16'h0001 : 16'h0000;
         prev_q <= line_in;
      end
   end
endmodule

/* File: tb/output_line_pulse_generator_bench.sv */
// bench for the output line pulse generator
`timescale 1ns/1ns
module output_line_pulse_generator_bench;
   import pulse_out_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [3:0]  address = 4'h0;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic        waitrequest;
   logic        in2 = 1'b0;
   logic        nc1 = 1'b0;
   logic        nc2 = 1'b0;
   logic        expo = 1'b0;
   logic        line_out;
   logic [7:0]  pulses;
   logic [15:0] width;
   logic [31:0] rd;
   int          failures = 0;
   int          tests_run = 0;
   always #25 clk = ~clk;
   // all byte lanes on: fields sit in lanes 0 and 1 only
   output_line_pulse_generator dut_u (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(4'hf), .readdata(readdata),
      .waitrequest(waitrequest), .second_input_pin(in2), .net_command_1(nc1),
      .net_command_2(nc2), .exposure_active(expo), .line_out(line_out));
   strobe_light light_u (.clk(clk), .rst_n(rst_n), .line_in(line_out), .count_q(pulses),
      .width_q(width));
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask
   // one avalon transfer: request held until waitrequest is seen low at a rising edge,
   // read data taken at that edge, then one idle edge before the next request
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      address   <= a;
      writedata <= d;
      write     <= wr;
      read      <= ~wr;
      do @(posedge clk); while (waitrequest !== 1'b0);
      rd = readdata;
      write <= 1'b0;
      read  <= 1'b0;
      @(posedge clk);
   endtask
   task automatic cfg(input logic [2:0] s, input logic [1:0] e, input logic [15:0] l,
      input logic [15:0] w);
      bus(1'b1, ctrl_offset, {26'h0, e, 1'b0, s});
      bus(1'b1, lead_offset, {16'h0, l});
      bus(1'b1, width_offset, {16'h0, w});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic t_reset;
      bus(1'b0, ctrl_offset, 32'h0);
      check("ctrl", 32'h0, rd);
      bus(1'b0, lead_offset, 32'h0);
      check("lead", 32'h0, rd);
      bus(1'b0, width_offset, 32'h0);
      check("width", 32'h1, rd);
      bus(1'b1, 4'h2, 32'hffff);
      bus(1'b0, 4'h2, 32'h0);
      check("unmapped", 32'h0, rd);
      bus(1'b0, ctrl_offset, 32'h0);
      check("ctrl kept", 32'h0, rd);
      $display("test reset done");
   endtask
   // each mode sees one rise and one fall of input 2
   task automatic t_edges;
      logic [7:0] p0;
      for (int e = 0; e < 3; e++) begin
         cfg(3'h0, 2'(e), 16'h0, 16'h1);
         p0 = pulses;
         in2 <= 1'b1;
         cyc(60);
         in2 <= 1'b0;
         cyc(60);
         check("edge pulses", (e == 2) ? 32'h2 : 32'h1, 32'(pulses - p0));
      end
      $display("test edges done");
   endtask
   task automatic t_net;
      logic [7:0] p0;
      for (int s = 1; s < 3; s++) begin
         cfg(3'(s), 2'h0, 16'h0, 16'h1);
         p0 = pulses;
         nc1 <= 1'b1;
         cyc(1);
         nc1 <= 1'b0;
         cyc(60);
         check("net one", (s == 1) ? 32'h1 : 32'h0, 32'(pulses - p0));
         nc2 <= 1'b1;
         cyc(1);
         nc2 <= 1'b0;
         cyc(60);
         check("net both", 32'h1, 32'(pulses - p0));
      end
      $display("test net done");
   endtask
   task automatic t_host;
      logic [7:0] p0;
      cfg(3'h3, 2'h1, 16'h0, 16'h2);
      p0 = pulses;
      bus(1'b1, fire_offset, 32'h1);
      cyc(60);
      check("bit0 fire", 32'h0, 32'(pulses - p0));
      bus(1'b1, fire_offset, 32'h2);
      bus(1'b0, fire_offset, 32'h0);
      check("line read", 32'h1, rd);
      cyc(80);
      check("host pulse", 32'h1, 32'(pulses - p0));
      check("host width", 32'd40, 32'(width));
      $display("test host done");
   endtask
   // second fire lands during the lead time and must be dropped
   task automatic t_lead;
      logic [7:0] p0;
      int         n;
      cfg(3'h3, 2'h0, 16'h3, 16'h1);
      p0 = pulses;
      bus(1'b1, fire_offset, 32'h2);
      bus(1'b1, fire_offset, 32'h2);
      bus(1'b0, ctrl_offset, 32'h0);
      check("lead state", 32'h1, 32'(rd[7:6]));
      n = 6;
      while (line_out !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      check("lead time", 32'h1, 32'(n >= 58 && n <= 66));
      cyc(140);
      check("lead pulses", 32'h1, 32'(pulses - p0));
      check("lead width", 32'd20, 32'(width));
      $display("test lead done");
   endtask
   task automatic t_expo;
      cfg(3'h4, 2'h0, 16'h5, 16'h1);
      expo <= 1'b1;
      cyc(30);
      expo <= 1'b0;
      cyc(5);
      check("expo width", 32'd30, 32'(width));
      check("expo low", 32'h0, 32'(line_out));
      $display("test expo done");
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // watchdog sized well past the roughly eleven hundred cycles of tests
   initial begin
      cyc(20000);
      failures++;
      close_out();
   end
   initial begin
      cyc(4);
      rst_n <= 1'b1;
      cyc(1);
      t_reset();
      t_edges();
      t_net();
      t_host();
      t_lead();
      t_expo();
      close_out();
   end
endmodule
